// *** core/eac_top.sv ***
// EEPROM access control: control, address and data registers, array and timing
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_top
   import eac_pkg::*;
#(
   parameter logic [16:0] ATOMIC_OSC = 17'(`EAC_CPU_WRITE_OSC),
   parameter logic [16:0] SPLIT_OSC = 17'(`EAC_CPU_WRITE_OSC * `EAC_SPLIT_US / `EAC_ATOMIC_US)
)
(
   // Clock and resets
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic nPor,
   // CPU I/O register port
   input wire eac_io_t ioReq,
   output logic [7:0] ioRdData_r,
   // CPU side status
   input wire logic globalIrqFlag,
   input wire logic flashSelfprogActive,
   input wire logic upperAreaLockFuse,
   // Calibrated RC oscillator, asynchronous
   input wire logic rcOsc,
   // Outputs to the CPU core
   output logic readyIrqReq_r,
   output logic cpuStall_r
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   eac_mode_t mode_r, progMode_r, startMode;
   logic rie_r, arm_r, wstb_r, rstb_r;
   logic [1:0] armCnt_r, stallCnt_r;
   logic [8:0] addr_r, progAddr_r;
   logic [7:0] data_r, progData_r, curByte, newByte;
   logic [7:0] mem [`EAC_DEPTH];
   logic [2:0] oscSync_r;
   logic oscLvl_r, oscTick;
   logic ctrlWr, armLoad, startReq, lockHit, startOk, rdEvent, tmrBusy, tmrDone;

   assign ctrlWr = ioReq.wr && (ioReq.sel == `EAC_SEL_CTRL);
   assign startMode = eac_mode_t'(ioReq.data[`EAC_BIT_PMHI:`EAC_BIT_PMLO]);
   assign armLoad = ctrlWr && ioReq.data[`EAC_BIT_ARM];
   assign startReq = ctrlWr && ioReq.data[`EAC_BIT_WSTB] && !wstb_r && arm_r
                     && !flashSelfprogActive;
   assign lockHit = (upperAreaLockFuse && (addr_r > `EAC_LOCK_TOP))
                    || (addr_r > `EAC_LAST_ADDR);
   assign startOk = startReq && (startMode != PM_RSVD) && !lockHit;
   assign rdEvent = ctrlWr && ioReq.data[`EAC_BIT_RSTB] && !wstb_r;
   assign curByte = (addr_r > `EAC_LAST_ADDR) ? `EAC_BYTE_RST : mem[addr_r];

   // ----------------------------------------
   // RC oscillator sync, three stages
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge nPor) begin
      if (!nPor) begin
         oscSync_r <= 3'h0;
         oscLvl_r <= 1'b0;
      end else begin
         oscSync_r <= {oscSync_r[1:0], rcOsc};
         if (oscSync_r[1] == oscSync_r[2]) begin
            oscLvl_r <= oscSync_r[2];
         end
      end
   end
   assign oscTick = (oscSync_r[1] == oscSync_r[2]) && oscSync_r[2] && !oscLvl_r;

   // ----------------------------------------
   // Programming engine
   // ----------------------------------------
   // Engine sits on power-on reset so a system reset never cuts a write short
   eac_prog_timer u_timer (
      .clk_sys(clk_sys),
      .nPor(nPor),
      .start(startOk),
      .loadCnt((startMode == PM_ATOMIC) ? ATOMIC_OSC : SPLIT_OSC),
      .oscTick(oscTick),
      .busy(tmrBusy),
      .done(tmrDone)
   );

   always_ff @(posedge clk_sys or negedge nPor) begin
      if (!nPor) begin
         wstb_r <= 1'b0;
         progMode_r <= PM_ATOMIC;
         progAddr_r <= `EAC_ADDR_RST;
         progData_r <= `EAC_BYTE_RST;
      end else if (startReq) begin
         wstb_r <= 1'b1;
         progMode_r <= startMode;
         progAddr_r <= addr_r;
         progData_r <= data_r;
      end else if (wstb_r && !tmrBusy) begin
         wstb_r <= 1'b0;
      end
   end

   always_comb begin
      case (progMode_r)
         PM_ATOMIC: newByte = progData_r;
         PM_ERASE: newByte = `EAC_ERASED;
         PM_WRITE: newByte = progData_r & mem[progAddr_r];
         default: newByte = mem[progAddr_r];
      endcase
   end

   for (genvar i = 0; i < `EAC_DEPTH; i++) begin : g_mem
      always_ff @(posedge clk_sys) begin
         if (tmrDone && (progAddr_r == 9'(i))) begin
            mem[i] <= newByte;
         end
      end
   end

   // ----------------------------------------
   // Mode field
   // ----------------------------------------
   // System reset acts on the clock here, since a busy engine must keep its mode
   always_ff @(posedge clk_sys or negedge nPor) begin
      if (!nPor) begin
         mode_r <= PM_ATOMIC;
      end else if (!wstb_r) begin
         if (!nrst) begin
            mode_r <= PM_ATOMIC;
         end else if (ctrlWr) begin
            mode_r <= startMode;
         end
      end
   end

   // ----------------------------------------
   // Control bits, address and data
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rie_r <= 1'b0;
         arm_r <= 1'b0;
         armCnt_r <= 2'h0;
      end else begin
         if (ctrlWr) begin
            rie_r <= ioReq.data[`EAC_BIT_RIE];
         end
         if (startReq) begin
            arm_r <= 1'b0;
         end else if (armLoad) begin
            arm_r <= 1'b1;
            armCnt_r <= 2'(`EAC_ARM_CYC - 3'h1);
         end else if (arm_r) begin
            if (armCnt_r == 2'h0) begin
               arm_r <= 1'b0;
            end else begin
               armCnt_r <= armCnt_r - 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         addr_r <= `EAC_ADDR_RST;
         data_r <= `EAC_BYTE_RST;
         rstb_r <= 1'b0;
      end else begin
         rstb_r <= rdEvent;
         if (rdEvent) begin
            data_r <= curByte;
         end else if (ioReq.wr && (ioReq.sel == `EAC_SEL_DATA)) begin
            data_r <= ioReq.data;
         end
         if (ioReq.wr && !wstb_r && (ioReq.sel == `EAC_SEL_ADRL)) begin
            addr_r[7:0] <= ioReq.data;
         end
         if (ioReq.wr && !wstb_r && (ioReq.sel == `EAC_SEL_ADRH)) begin
            addr_r[8] <= ioReq.data[0];
         end
      end
   end

   // ----------------------------------------
   // CPU stall, ready request, read-back
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stallCnt_r <= 2'h0;
         cpuStall_r <= 1'b0;
      end else if (startOk) begin
         stallCnt_r <= 2'(`EAC_WR_STALL - 3'h1);
         cpuStall_r <= 1'b1;
      end else if (rdEvent) begin
         stallCnt_r <= 2'(`EAC_RD_STALL - 3'h1);
         cpuStall_r <= 1'b1;
      end else if (stallCnt_r != 2'h0) begin
         stallCnt_r <= stallCnt_r - 2'h1;
      end else begin
         cpuStall_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         readyIrqReq_r <= 1'b0;
         ioRdData_r <= `EAC_BYTE_RST;
      end else begin
         readyIrqReq_r <= rie_r && globalIrqFlag && !wstb_r;
         case (ioReq.sel)
            `EAC_SEL_CTRL: ioRdData_r <= {`EAC_RSV_ZERO, mode_r, rie_r,
                                          arm_r, wstb_r, rstb_r};
            `EAC_SEL_DATA: ioRdData_r <= data_r;
            `EAC_SEL_ADRL: ioRdData_r <= addr_r[7:0];
            default: ioRdData_r <= {7'h00, addr_r[8]};
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence armQuiet4;
      (!armLoad && !startReq)[*4];
   endsequence

   sequence strobeWindow;
      wstb_r ##1 !wstb_r;
   endsequence

   rsv_bits_a: assert property ((ioReq.sel == `EAC_SEL_CTRL) |=> ioRdData_r[7:6] == 2'h0)
      else $error("reserved control bits read nonzero");
   mode_hold_a: assert property (wstb_r |=> $stable(mode_r))
      else $error("mode changed while strobe set");
   arm_timeout_a: assert property (armLoad ##1 armQuiet4 |-> arm_r ##1 !arm_r)
      else $error("arm bit did not clear after four clocks");
   no_arm_a: assert property (ctrlWr && ioReq.data[1] && !arm_r && !wstb_r |=> !wstb_r)
      else $error("strobe accepted without arm");
   strobe_clear_a: assert property (tmrDone |-> wstb_r ##1 !wstb_r)
      else $error("strobe not cleared after programming");
   busy_strobe_a: assert property (tmrBusy |-> wstb_r)
      else $error("programming without strobe set");
   write_stall_a: assert property (startOk |=> cpuStall_r[*2] ##1 !cpuStall_r)
      else $error("write stall not two cycles");
   read_stall_a: assert property (rdEvent |=> cpuStall_r[*4] ##1 !cpuStall_r)
      else $error("read stall not four cycles");
   addr_frozen_a: assert property (wstb_r |=> $stable(addr_r))
      else $error("address changed during programming");
   read_block_a: assert property (wstb_r && ctrlWr && ioReq.data[`EAC_BIT_RSTB]
      |=> !rstb_r && $stable(data_r))
      else $error("read accepted during programming");
   flash_block_a: assert property (ctrlWr && ioReq.data[`EAC_BIT_WSTB] && flashSelfprogActive
      && !wstb_r |=> !wstb_r)
      else $error("write started during flash programming");
   irq_level_a: assert property (rie_r && globalIrqFlag && !wstb_r |=> readyIrqReq_r)
      else $error("ready request not held");
   rsvd_mode_a: assert property (startReq && !startOk |=> strobeWindow and !tmrBusy)
      else $error("reserved or locked strobe misbehaved");
endmodule : eac_top

// *** core/eac_map.svh ***
// Offsets, field positions, reset values and timing counts of the EEPROM access control
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH
// ----------------------------------------
// Register selects on the CPU I/O port
// ----------------------------------------
`define EAC_SEL_CTRL 2'h0
`define EAC_SEL_DATA 2'h1
`define EAC_SEL_ADRL 2'h2
`define EAC_SEL_ADRH 2'h3
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define EAC_BIT_RSTB 0
`define EAC_BIT_WSTB 1
`define EAC_BIT_ARM 2
`define EAC_BIT_RIE 3
`define EAC_BIT_PMLO 4
`define EAC_BIT_PMHI 5
`define EAC_RSV_ZERO 2'h0
`define EAC_BYTE_RST 8'h00
`define EAC_ADDR_RST 9'h000
// ----------------------------------------
// Address space
// ----------------------------------------
`define EAC_LOCK_TOP 9'h0FF
`define EAC_LAST_ADDR 9'h13F
`define EAC_DEPTH 320
`define EAC_ERASED 8'hFF
// ----------------------------------------
// Timing
// ----------------------------------------
`define EAC_ARM_CYC 3'h4
`define EAC_WR_STALL 3'h2
`define EAC_RD_STALL 3'h4
`define EAC_ATOMIC_US 3400
`define EAC_SPLIT_US 1800
`define EAC_CPU_WRITE_US 8500
`define EAC_CPU_WRITE_OSC 67584
`endif

// *** core/eac_pkg.sv ***
// Types shared by the EEPROM access control modules
package eac_pkg;
   typedef enum logic [1:0] {PM_ATOMIC, PM_ERASE, PM_WRITE, PM_RSVD} eac_mode_t;
   typedef enum logic {TMR_IDLE, TMR_RUN} eac_tmr_st_t;
   typedef struct packed {
      logic wr;
      logic [1:0] sel;
      logic [7:0] data;
   } eac_io_t;
endpackage : eac_pkg

// *** core/eac_prog_timer.sv ***
// Programming timer counting ticks of the calibrated RC oscillator
`timescale 1ns/1ps
module eac_prog_timer
   import eac_pkg::*;
(
   // Clock and power-on reset
   input wire logic clk_sys,
   input wire logic nPor,
   // Control
   input wire logic start,
   input wire logic [16:0] loadCnt,
   input wire logic oscTick,
   // Status
   output logic busy,
   output logic done
);
   eac_tmr_st_t st_r;
   logic [16:0] cnt_r;

   always_ff @(posedge clk_sys or negedge nPor) begin
      if (!nPor) begin
         st_r <= TMR_IDLE;
         cnt_r <= 17'h0_0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_r)
            TMR_IDLE: begin
               if (start) begin
                  cnt_r <= loadCnt;
                  st_r <= TMR_RUN;
               end
            end
            TMR_RUN: begin
               if (oscTick) begin
                  if (cnt_r <= 17'h0_0001) begin
                     done <= 1'b1;
                     st_r <= TMR_IDLE;
                  end else begin
                     cnt_r <= cnt_r - 17'h0_0001;
                  end
               end
            end
            default: st_r <= TMR_IDLE;
         endcase
      end
   end

   assign busy = (st_r == TMR_RUN);
endmodule : eac_prog_timer

// *** verif/eac_cpu_model.sv ***
// CPU core model driving the EEPROM control I/O port
`timescale 1ns/1ps
module eac_cpu_model
   import eac_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Register port
   output eac_io_t ioReq,
   input wire logic [7:0] ioRdData_r
);
   initial ioReq = '0;
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   task automatic wr(input logic [1:0] sel, input logic [7:0] data);
      @(posedge clk_sys);
      ioReq <= '{wr: 1'b1, sel: sel, data: data};
      @(posedge clk_sys);
      ioReq.wr <= 1'b0;
   endtask : wr
   // Read data is a flop, so it is taken one edge after sel
   task automatic rd(input logic [1:0] sel, output logic [7:0] data);
      @(posedge clk_sys);
      ioReq.sel <= sel;
      @(posedge clk_sys);
      #1 data = ioRdData_r;
   endtask : rd
   // Caller has already seen the strobe idle
   task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
      wr(2'h3, {7'h00, a[8]});
      wr(2'h2, a[7:0]);
      wr(2'h1, d);
      wr(2'h0, 8'h04);
      wr(2'h0, {2'h0, m, 4'h2});
   endtask : prog
endmodule : eac_cpu_model

// *** verif/eac_top_tb.sv ***
// Self-checking bench for the EEPROM access control
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_top_tb
   import eac_pkg::*;
;
   localparam logic [16:0] ATOMIC = 17'h0_0014;
   localparam logic [16:0] SPLIT = 17'h0_000A;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic nPor = 1'b0;
   logic globalIrqFlag = 1'b0;
   logic flashSelfprogActive = 1'b0;
   logic upperAreaLockFuse = 1'b0;
   logic rcOsc = 1'b0;
   eac_io_t ioReq;
   logic [7:0] ioRdData_r;
   logic readyIrqReq_r;
   logic cpuStall_r;
   logic [7:0] mem [0:`EAC_DEPTH-1];
   logic [31:0] seed = 32'h389d_7e7e;
   int errors = 0;
   int comparisons = 0;
   always #2 clk_sys = ~clk_sys;
   // Odd half period keeps the oscillator out of phase with the clock
   always #23.9 rcOsc = ~rcOsc;
   eac_top #(.ATOMIC_OSC(ATOMIC), .SPLIT_OSC(SPLIT)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
      .nPor(nPor), .ioReq(ioReq), .ioRdData_r(ioRdData_r), .globalIrqFlag(globalIrqFlag),
      .flashSelfprogActive(flashSelfprogActive), .upperAreaLockFuse(upperAreaLockFuse),
      .rcOsc(rcOsc), .readyIrqReq_r(readyIrqReq_r), .cpuStall_r(cpuStall_r));
   eac_cpu_model u_cpu (.clk_sys(clk_sys), .ioReq(ioReq), .ioRdData_r(ioRdData_r));
   // ----------------------------------------
   // Checks and helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t byte exp %h got %h", $time, exp, got);
      end
   endtask : chk_byte
   task automatic chk_cnt(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t count exp %h got %h", $time, exp, got);
      end
   endtask : chk_cnt
   task automatic stall_cnt(output int n);
      n = 0;
      // First sample lands in the cycle the stall is launched, else one is lost
      repeat (8) begin
         #1 n += (cpuStall_r === 1'b1);
         @(posedge clk_sys);
      end
   endtask : stall_cnt
   task automatic wait_idle(output int n);
      logic [7:0] c;
      c = 8'h02;
      for (n = 0; c[1] !== 1'b0; n += 2) begin
         if (n > 2000) begin
            chk_byte(8'h00, c);
            close_out();
         end
         u_cpu.rd(2'h0, c);
      end
   endtask : wait_idle
   task automatic irq_is(input logic e);
      repeat (3) @(posedge clk_sys);
      #1 chk_byte({7'h00, e}, {7'h00, readyIrqReq_r});
   endtask : irq_is
   task automatic do_write(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
         input logic ok);
      int n;
      int t;
      logic go;
      logic [7:0] b;
      go = ok && m != 2'h3;
      t = int'(((m == 2'h0) ? ATOMIC : SPLIT) * 47.8 / 4.0);
      wait_idle(n);
      u_cpu.prog(a, d, m);
      stall_cnt(n);
      chk_cnt(go ? `EAC_WR_STALL : 0, n);
      wait_idle(n);
      chk_cnt(1, go ? (n + 8 > t - 16 && n + 8 < t + 16) : n == 2);
      if (go) begin
         mem[a] = (m == 2'h0) ? d : (m == 2'h1) ? 8'hFF : mem[a] & d;
      end
      u_cpu.wr(2'h3, {7'h00, a[8]});
      u_cpu.wr(2'h2, a[7:0]);
      u_cpu.wr(2'h0, 8'h01);
      stall_cnt(n);
      chk_cnt(`EAC_RD_STALL, n);
      u_cpu.rd(2'h1, b);
      chk_byte(mem[a], b);
   endtask : do_write
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] b;
      logic [8:0] a;
      int n;
      repeat (6) @(posedge clk_sys);
      nPor <= 1'b1;
      nrst <= 1'b1;
      u_cpu.rd(2'h0, b);
      chk_byte(8'h00, b);
      u_cpu.wr(2'h0, 8'hC8);
      u_cpu.rd(2'h0, b);
      chk_byte(8'h08, b);
      // Modes run 00, 11, 10, 01, 00 so the AND follows known data
      for (int j = 0; j < 3; j++) begin
         seed = lfsr(seed);
         a = (j == 0) ? `EAC_LAST_ADDR : (j == 1) ? {1'b0, seed[7:0]} : 9'h000;
         for (int m = 0; m < 5; m++) begin
            seed = lfsr(seed);
            do_write(a, seed[15:8], m[1:0] ^ {m[0], 1'b0}, 1'b1);
         end
      end
      @(posedge clk_sys) upperAreaLockFuse <= 1'b1;
      do_write(`EAC_LOCK_TOP, seed[23:16], 2'h0, 1'b1);
      do_write(`EAC_LAST_ADDR, seed[31:24], 2'h0, 1'b0);
      @(posedge clk_sys) flashSelfprogActive <= 1'b1;
      do_write(9'h000, seed[23:16], 2'h0, 1'b0);
      @(posedge clk_sys) flashSelfprogActive <= 1'b0;
      u_cpu.wr(2'h0, 8'h02);
      u_cpu.rd(2'h0, b);
      chk_byte(8'h00, b);
      u_cpu.wr(2'h0, 8'h04);
      u_cpu.rd(2'h0, b);
      chk_byte(8'h04, b);
      repeat (4) @(posedge clk_sys);
      u_cpu.wr(2'h0, 8'h02);
      u_cpu.rd(2'h0, b);
      chk_byte(8'h00, b);
      seed = lfsr(seed);
      a = {1'b0, seed[7:0]};
      u_cpu.prog(a, seed[15:8], 2'h0);
      u_cpu.wr(2'h2, ~a[7:0]);
      u_cpu.wr(2'h0, 8'h21);
      u_cpu.rd(2'h0, b);
      chk_byte(8'h02, b);
      u_cpu.rd(2'h2, b);
      chk_byte(a[7:0], b);
      u_cpu.rd(2'h1, b);
      chk_byte(seed[15:8], b);
      wait_idle(n);
      @(posedge clk_sys) globalIrqFlag <= 1'b1;
      u_cpu.wr(2'h0, 8'h08);
      irq_is(1'b1);
      irq_is(1'b1);
      u_cpu.wr(2'h0, 8'h0C);
      u_cpu.wr(2'h0, 8'h0A);
      irq_is(1'b0);
      wait_idle(n);
      irq_is(1'b1);
      @(posedge clk_sys) globalIrqFlag <= 1'b0;
      irq_is(1'b0);
      // Interrupts stay off through the write sequence
      u_cpu.prog(a, seed[7:0], 2'h2);
      @(posedge clk_sys) nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      u_cpu.rd(2'h0, b);
      chk_byte(8'h22, b);
      wait_idle(n);
      @(posedge clk_sys) nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      u_cpu.rd(2'h0, b);
      chk_byte(8'h00, b);
      close_out();
   end
endmodule : eac_top_tb
